// ---- verilog/spi_sd_pkg.sv ----
// Package: register map, field positions, reset values and timing for the SPI status/data block
package spi_sd_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'hC3;
  localparam logic [7:0] IDX_STATUS = 8'hC4;
  localparam logic [7:0] IDX_DATA = 8'hC5;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_DATA = {IDX_DATA, 2'b00};

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_RATE2 = 7;
  localparam int CTL_ENABLE = 6;
  localparam int CTL_SSDISABLE = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_IDLE_LEVEL = 3;
  localparam int CTL_SAMPLE_EDGE = 2;
  localparam int CTL_RATE1 = 1;
  localparam int CTL_RATE0 = 0;
  localparam logic [7:0] CTL_RESET = 8'h14;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int STA_DONE = 7;
  localparam int STA_COLLISION = 6;
  localparam int STA_EARLY = 5;
  localparam int STA_FAULT = 4;
  localparam logic [3:0] STA_RESERVED_VALUE = 4'h0;

  // ----------------------------------------
  // Timing and widths
  // ----------------------------------------
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] BIT_COUNT_W = 4'h8;
  localparam int HALF_CNT_W = 8;
  localparam logic [2:0] RATE_INVALID = 3'h7;
  localparam int SYNC_STAGES = 2;

  // Link pins grouped together
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spi_pins_t;

endpackage

// ---- verilog/spi_sync_bit.sv ----
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module spi_sync_bit
  import spi_sd_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_async,
  output logic o_sync
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb
  begin
    state_next.meta = i_async;
    state_next.stable = state_reg.meta;
  end

  // Register both stages
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_reg <= {RESET_LEVEL, RESET_LEVEL};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.stable;

endmodule
`default_nettype wire

// ---- verilog/spi_edge_gen.sv ----
// Serial clock generator for master mode: divides the system clock by the selected rate
`timescale 1ns/100ps
`default_nettype none
module spi_edge_gen
  import spi_sd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic [2:0] i_rate,
  output logic o_toggle
);

  typedef struct packed {
    logic [HALF_CNT_W-1:0] count;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;
  logic [HALF_CNT_W-1:0] half_period;

  // Half of divide-by 2^(rate+1) in system clocks; invalid rate stalls
  always_comb
  begin
    half_period = HALF_CNT_W'(1) << i_rate;
    state_next = state_reg;
    o_toggle = 1'b0;
    if (!i_run || i_rate == RATE_INVALID)
    begin
      state_next.count = '0;
    end
    else if (state_reg.count == half_period - HALF_CNT_W'(1))
    begin
      state_next.count = '0;
      o_toggle = 1'b1;
    end
    else
    begin
      state_next.count = state_reg.count + HALF_CNT_W'(1);
    end
  end

  // Divider counter
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/spi_status_data.sv ----
// SPI status flags, data path and shift engine with control/status/data registers
//
// Overview of operation
// - Set done flag when transfer completes
// - Done flag clear during transfer, clearing sequence
// - Set collision flag on data write mid-transfer
// - Collision flag zero otherwise, cleared by sequence
// - Slave: select released mid-byte sets early flag
// - Early flag cleared only by disabling
// - Select pin inconsistent with mode sets fault
// - Fault clear otherwise, cleared by sequence
// - Status bits three to zero reserved
// - Data write loads shift register directly
// - Data read returns receive buffer only
// - Registers freely accessible when idle
// - Disabling aborts transfer at once
// - Data write mid-transfer is overflow
// - Status read with fault, control write clears
// - Status then data access clears collision
// - Fault clears enable and master, error request
// - Done flag raises transfer request
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module spi_status_data
  import spi_sd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  input wire logic i_ss_n,
  output logic o_sck,
  output logic o_sck_oe_n,
  output logic o_mosi,
  output logic o_mosi_oe_n,
  output logic o_miso,
  output logic o_miso_oe_n,
  output logic o_transfer_irq,
  output logic o_error_irq,
  output logic o_busy
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum {ST_IDLE, ST_SHIFT} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [7:0] control;
    logic done;
    logic collision;
    logic early_release;
    logic fault;
    logic [7:0] shifter;
    logic [7:0] rx_buffer;
    logic [3:0] bits;
    logic sck_level;
    logic sample_bit;
    logic lead_half;
    logic sck_prev;
    logic status_seen;
    logic fault_seen;
    logic [7:0] rdata;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  spi_pins_t pins_sync;
  logic toggle;
  logic enabled;
  logic master;
  logic ss_active;
  logic slave_edge;
  logic slave_start;
  logic shift_edge;
  logic sample_edge;
  logic finish;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  spi_sync_bit #(.RESET_LEVEL(1'b0)) u_sync_sck (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(i_sck),
    .o_sync(pins_sync.sck));
  spi_sync_bit #(.RESET_LEVEL(1'b0)) u_sync_mosi (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(i_mosi),
    .o_sync(pins_sync.mosi));
  spi_sync_bit #(.RESET_LEVEL(1'b0)) u_sync_miso (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(i_miso),
    .o_sync(pins_sync.miso));
  spi_sync_bit #(.RESET_LEVEL(1'b1)) u_sync_ss (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_async(i_ss_n),
    .o_sync(pins_sync.ss_n));

  // Master serial clock divider, runs only while shifting as master
  spi_edge_gen u_edge_gen (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_run(master && state_reg.phase == ST_SHIFT),
    .i_rate({state_reg.control[CTL_RATE2], state_reg.control[CTL_RATE1], state_reg.control[CTL_RATE0]}),
    .o_toggle(toggle)
  );

  assign enabled = state_reg.control[CTL_ENABLE];
  assign master = state_reg.control[CTL_MASTER];
  assign ss_active = !pins_sync.ss_n && !state_reg.control[CTL_SSDISABLE];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.sck_prev = pins_sync.sck;
    slave_edge = pins_sync.sck != state_reg.sck_prev;
    slave_start = !master && enabled && ss_active && slave_edge && state_reg.phase == ST_IDLE;
    shift_edge = 1'b0;
    sample_edge = 1'b0;
    finish = 1'b0;

    // Serial engine: sample on leading edge when phase bit is 0, trailing when 1
    if (state_reg.phase == ST_SHIFT || slave_start)
    begin
      if (master ? toggle : slave_edge)
      begin
        if (master)
        begin
          state_next.sck_level = !state_reg.sck_level;
        end
        // First edge of each pair leaves the idle level
        if (state_reg.lead_half == state_reg.control[CTL_SAMPLE_EDGE])
        begin
          sample_edge = 1'b1;
        end
        else
        begin
          shift_edge = 1'b1;
        end
        state_next.lead_half = !state_reg.lead_half;
      end
      if (sample_edge)
      begin
        state_next.sample_bit = master ? pins_sync.miso : pins_sync.mosi;
        state_next.bits = state_reg.bits + 4'h1;
        // Trailing-edge sampling has no shift edge after its last bit
        if (state_reg.control[CTL_SAMPLE_EDGE] && state_reg.bits == BIT_COUNT_W - 4'h1)
        begin
          state_next.shifter = {state_reg.shifter[6:0], master ? pins_sync.miso : pins_sync.mosi};
        end
      end
      // Nothing sampled yet on the very first shift edge
      if (shift_edge && state_reg.bits != 4'h0)
      begin
        state_next.shifter = {state_reg.shifter[6:0], state_reg.sample_bit};
      end
      // Byte complete on the eighth trailing edge, clock back at idle
      if (state_reg.lead_half && (sample_edge || shift_edge) && state_next.bits == BIT_COUNT_W)
      begin
        finish = 1'b1;
        state_next.phase = ST_IDLE;
        state_next.rx_buffer = state_next.shifter;
        state_next.done = 1'b1;
      end
      // Select released before byte end in slave mode
      if (!master && pins_sync.ss_n && !finish)
      begin
        state_next.early_release = 1'b1;
        state_next.phase = ST_IDLE;
      end
    end
    // Slave starts on its first clock edge; idle keeps counters at zero so that edge counts
    if (slave_start)
    begin
      state_next.phase = ST_SHIFT;
      state_next.done = 1'b0;
    end
    else if (state_reg.phase == ST_IDLE)
    begin
      state_next.bits = 4'h0;
      state_next.lead_half = 1'b0;
    end

    // Register reads: data returns one cycle later
    state_next.rdata = 8'h00;
    if (i_read)
    begin
      case (i_addr)
        ADDR_CONTROL: state_next.rdata = state_reg.control;
        ADDR_STATUS: state_next.rdata = {state_reg.done, state_reg.collision, state_reg.early_release, state_reg.fault,
          STA_RESERVED_VALUE};
        ADDR_DATA: state_next.rdata = state_reg.rx_buffer;
        default: state_next.rdata = 8'h00;
      endcase
    end

    // Clearing sequences: status access arms, following access clears
    if ((i_read || i_write) && i_addr == ADDR_STATUS)
    begin
      state_next.status_seen = 1'b1;
      if (i_read && state_reg.fault)
      begin
        state_next.fault_seen = 1'b1;
      end
    end
    // A byte finishing in the clearing cycle keeps its done flag
    if ((i_read || i_write) && i_addr == ADDR_DATA && state_reg.status_seen)
    begin
      state_next.collision = 1'b0;
      if (!finish)
      begin
        state_next.done = 1'b0;
      end
      state_next.status_seen = 1'b0;
    end

    // Register writes, freely accepted while idle
    if (i_write)
    begin
      case (i_addr)
        ADDR_CONTROL:
        begin
          state_next.control = i_wdata;
          if (state_reg.fault_seen)
          begin
            state_next.fault = 1'b0;
            state_next.fault_seen = 1'b0;
          end
          if (!i_wdata[CTL_ENABLE])
          begin
            state_next.early_release = 1'b0;
            state_next.phase = ST_IDLE;
            state_next.sck_level = i_wdata[CTL_IDLE_LEVEL];
          end
          else if (state_reg.phase == ST_IDLE)
          begin
            state_next.sck_level = i_wdata[CTL_IDLE_LEVEL];
          end
        end
        ADDR_DATA:
        begin
          if (state_reg.phase == ST_SHIFT && !finish)
          begin
            // Overflow: byte dropped, transfer keeps going, no request
            state_next.collision = 1'b1;
          end
          else
          begin
            state_next.shifter = i_wdata;
            if (enabled && master)
            begin
              state_next.phase = ST_SHIFT;
              state_next.bits = 4'h0;
              state_next.lead_half = 1'b0;
              state_next.sck_level = state_reg.control[CTL_IDLE_LEVEL];
              state_next.done = 1'b0;
            end
          end
        end
        default:
        begin
        end
      endcase
    end

    // Mode fault: master sees select low; set beats clear
    if (enabled && master && ss_active)
    begin
      state_next.fault = 1'b1;
      state_next.control[CTL_ENABLE] = 1'b0;
      state_next.control[CTL_MASTER] = 1'b0;
      state_next.phase = ST_IDLE;
      state_next.sck_level = state_reg.control[CTL_IDLE_LEVEL];
    end
    if (!state_next.control[CTL_ENABLE])
    begin
      state_next.phase = ST_IDLE;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_reg <= '0;
      state_reg.phase <= ST_IDLE;
      state_reg.control <= CTL_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Master drives clock and data out; slave drives its data line only when selected
  assign o_sck = state_reg.sck_level;
  assign o_sck_oe_n = !(enabled && master);
  assign o_mosi = state_reg.shifter[7];
  assign o_mosi_oe_n = !(enabled && master);
  assign o_miso = state_reg.shifter[7];
  assign o_miso_oe_n = !(enabled && !master && !pins_sync.ss_n);
  assign o_rdata = state_reg.rdata;
  assign o_transfer_irq = state_reg.done;
  assign o_error_irq = state_reg.fault && !state_reg.control[CTL_SSDISABLE];
  assign o_busy = state_reg.phase == ST_SHIFT;

endmodule
`default_nettype wire

// ---- testbench/spi_status_data_assertions.sv ----
// Port-level checker for the SPI status/data block
`timescale 1ns/100ps
`default_nettype none
module spi_status_data_assertions
  import spi_sd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] o_rdata,
  input wire logic o_transfer_irq,
  input wire logic o_error_irq,
  input wire logic o_busy
);
  // ----
  // Helpers
  // ----
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic sta_rd;
  // Status read strobe, reused by several checks
  assign sta_rd = i_read && (i_addr == ADDR_STATUS);

  // ----
  // Checks
  // ----
  a_reset_quiet: assert property ($past(i_sys_rst) |-> !o_transfer_irq && !o_error_irq && !o_busy)
    else $error("flags or busy set after reset");
  a_idle_rdata: assert property (!$past(i_read) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_reserved_zero: assert property ($past(sta_rd) |-> o_rdata[3:0] == STA_RESERVED_VALUE)
    else $error("reserved status bits wrong");
  // Read data lags the irq by one register stage
  a_done_irq: assert property ($past(sta_rd) && o_rdata[STA_DONE] |-> o_transfer_irq || $past(o_transfer_irq))
    else $error("done flag read without transfer irq");
  a_busy_no_done: assert property (o_busy && $past(o_busy) |-> !o_transfer_irq)
    else $error("done flag set while shifting");
  a_fault_stops: assert property (o_error_irq && $past(o_error_irq) |-> !o_busy)
    else $error("still shifting after mode fault");
  a_fault_source: assert property ($past(sta_rd) && !o_rdata[STA_FAULT] |-> !$past(o_error_irq))
    else $error("error irq without mode fault");
  a_disable_aborts: assert property (i_write && i_addr == ADDR_CONTROL && !i_wdata[CTL_ENABLE] |=> !o_busy)
    else $error("transfer survived disable");
  a_collision_continue: assert property (i_write && i_addr == ADDR_DATA && o_busy |=> o_busy || o_transfer_irq)
    else $error("collision disturbed transfer");
endmodule

bind spi_status_data spi_status_data_assertions u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
  .o_transfer_irq(o_transfer_irq), .o_error_irq(o_error_irq), .o_busy(o_busy));
`default_nettype wire

// ---- testbench/spi_far_end.sv ----
// Far-side SPI device: slave when the block masters, master when it is slave
`timescale 1ns/100ps
`default_nettype none
module spi_far_end
(
  input wire logic i_clock,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_miso,
  output logic o_ss_n
);
  logic [7:0] s_sr = 8'h00;
  logic [7:0] s_rx = 8'h00;
  logic m_on = 1'b0;
  logic m_sck = 1'b0;
  logic m_mosi = 1'b0;
  logic ss_n = 1'b1;
  logic junk = 1'b0;

  // Undriven lines wiggle so stale values never pass
  always @(posedge i_clock)
    junk <= ~junk;
  // Slave role: sample on leading edge, shift on trailing
  always @(posedge i_sck)
    if (!m_on)
      s_rx <= {s_rx[6:0], i_mosi};
  always @(negedge i_sck)
    if (!m_on)
      s_sr <= s_sr << 1;
  assign o_miso = m_on ? junk : s_sr[7];
  assign o_mosi = (m_on && !ss_n) ? m_mosi : junk;
  assign o_sck = m_sck;
  assign o_ss_n = ss_n;

  // Master role: 160 ns link clock, clock stands still between frames
  task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    int i;
    m_on = 1'b1;
    rx = 8'h00;
    #3;
    ss_n = 1'b0;
    m_mosi = tx[7];
    #160;
    for (i = 0; i < n; i++)
    begin
      #80 m_sck = 1'b1;
      rx = {rx[6:0], i_miso};
      #80 m_sck = 1'b0;
      tx = tx << 1;
      m_mosi = tx[7];
    end
    #80 ss_n = 1'b1;
    m_on = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_spi_status_data.sv ----
// Self-checking bench for the SPI status/data block
`timescale 1ns/100ps
`default_nettype none
module tb_spi_status_data
  import spi_sd_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, t_irq, e_irq, busy;
  logic p_sck, p_mosi, p_miso, p_ss_n, sck_w, mosi_w, miso_w;
  logic [7:0] rx;
  int num_errors = 0;
  int total_checks = 0;

  // ----
  // Clock, pins and instances
  // ----
  always #2.5 clk = ~clk;
  // Pin level follows whoever enables its driver
  assign sck_w = sck_oe_n ? p_sck : sck_o;
  assign mosi_w = mosi_oe_n ? p_mosi : mosi_o;
  assign miso_w = miso_oe_n ? p_miso : miso_o;
  spi_status_data dut (.i_clock(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_write(wr_s), .i_read(rd_s), .o_rdata(rdata), .i_sck(sck_w), .i_mosi(mosi_w),
    .i_miso(miso_w), .i_ss_n(p_ss_n), .o_sck(sck_o), .o_sck_oe_n(sck_oe_n), .o_mosi(mosi_o),
    .o_mosi_oe_n(mosi_oe_n), .o_miso(miso_o), .o_miso_oe_n(miso_oe_n),
    .o_transfer_irq(t_irq), .o_error_irq(e_irq), .o_busy(busy));
  spi_far_end sp (.i_clock(clk), .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w),
    .o_sck(p_sck), .o_mosi(p_mosi), .o_miso(p_miso), .o_ss_n(p_ss_n));

  // ----
  // Tasks
  // ----
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One idle edge after each strobe keeps drivers single per step
  task wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task rc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clk);
  endtask
  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000)
      num_errors++;
  endtask
  task results;
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far beyond the few microseconds needed
  initial
  begin
    #100000;
    num_errors++;
    results;
  end

  // ----
  // Test sequence
  // ----
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(ADDR_STATUS, 8'h00);
    rc(ADDR_CONTROL, CTL_RESET);
    rc(10'h000, 8'h00);
    // Master byte with a collision in flight
    sp.s_sr = 8'h96;
    wr(ADDR_CONTROL, 8'h53);
    wr(ADDR_DATA, 8'hA5);
    rc(ADDR_STATUS, 8'h00);
    wr(ADDR_DATA, 8'h3C);
    wait_idle;
    rc(ADDR_STATUS, 8'hC0);
    chk({7'h00, t_irq}, 8'h01);
    chk(sp.s_rx, 8'hA5);
    rc(ADDR_DATA, 8'h96);
    rc(ADDR_STATUS, 8'h00);
    // Buffer keeps old byte while shifting
    sp.s_sr = 8'h81;
    wr(ADDR_DATA, 8'h0F);
    rc(ADDR_DATA, 8'h96);
    wait_idle;
    rc(ADDR_DATA, 8'h81);
    // Abort: only enable changes, rate and mode kept
    wr(ADDR_DATA, 8'h55);
    wr(ADDR_CONTROL, 8'h13);
    chk({7'h00, busy}, 8'h00);
    rc(ADDR_STATUS, 8'h00);
    // Mode fault from a second master pulling select low
    wr(ADDR_CONTROL, 8'h53);
    sp.ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({7'h00, e_irq}, 8'h01);
    rc(ADDR_STATUS, 8'h10);
    rc(ADDR_CONTROL, 8'h03);
    sp.ss_n <= 1'b1;
    repeat (8) @(posedge clk);
    wr(ADDR_CONTROL, 8'h03);
    rc(ADDR_STATUS, 8'h00);
    // Slave: full byte, then a byte cut short
    wr(ADDR_CONTROL, 8'h40);
    wr(ADDR_DATA, 8'h5A);
    sp.xfer(8'h96, 8, rx);
    @(posedge clk);
    wait_idle;
    rc(ADDR_STATUS, 8'h80);
    chk(rx, 8'h5A);
    rc(ADDR_DATA, 8'h96);
    sp.xfer(8'hF0, 4, rx);
    repeat (8) @(posedge clk);
    rc(ADDR_STATUS, 8'h20);
    wr(ADDR_CONTROL, 8'h40);
    rc(ADDR_STATUS, 8'h20);
    wr(ADDR_CONTROL, 8'h00);
    rc(ADDR_STATUS, 8'h00);
    results;
  end
endmodule
`default_nettype wire
